// ==== pia_irq_core.sv ====
// Interrupt summary, pin gating and port four register map behind the serial link
`timescale 1ns/1ps
`default_nettype none
module pia_irq_core #(
  parameter logic [6:0] DEV_ADDR = 7'h20
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Serial register link
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Event sources
  input wire logic [3:0] global_event_hi,
  input wire logic [2:0][7:0] other_port_events,
  input wire logic [7:0] port4_event_set,
  input wire pia_pkg::pia_p4_status_t port4_status,
  // Port four control outputs
  output logic [7:0] port4_configuration,
  output logic [7:0] port4_limit_timing,
  output logic [7:0] port4_overcurrent_threshold,
  output logic [7:0] port4_command_strobes,
  // Interrupt pin
  output logic int_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Link front end

  logic [1:0] line_sync;
  pia_pkg::pia_reg_req_t req;
  logic [7:0] rd_data;

  pia_sync #(
    .W(2)
  ) u_sync (
    .clock(clock),
    .srst(srst),
    .async_in({scl_in, sda_in}),
    .sync_out(line_sync)
  );

  pia_serial #(
    .DEV_ADDR(DEV_ADDR)
  ) u_serial (
    .clock(clock),
    .srst(srst),
    .scl(line_sync[1]),
    .sda(line_sync[0]),
    .sda_oe(sda_oe),
    .req(req),
    .rd_data(rd_data)
  );

  // Open-drain: only ever pulls low
  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Source collection

  pia_pkg::pia_core_state_t state;
  pia_pkg::pia_core_state_t next_state;
  logic [7:0] src;
  logic [7:0] rise;
  logic [7:0] gate;
  logic [7:0] type_mask;
  logic [3:0][7:0] port_events;
  logic [7:0] p4_evt_now;

  // Port four events as they stand this cycle, before any read clear
  assign p4_evt_now = state.p4_evt;
  assign port_events = {p4_evt_now, other_port_events[2], other_port_events[1],
                        other_port_events[0]};

  // Limit and cut timeouts share one mask bit; the rest map one to one
  assign type_mask = {state.mask[pia_pkg::MASK_IFAULT_BIT], state.mask[6:0]};

  genvar p;
  generate
    for (p = 0; p < pia_pkg::NUM_PORTS; p++) begin : g_port
      assign src[p] = |port_events[p];
      // A port reaches the pin only through event types left unmasked
      assign gate[p] = state.summary[p] & |(port_events[p] & type_mask);
    end
  endgenerate

  // Thermal, switch failure, logic and main supply lockouts in that order
  assign src[7:4] = global_event_hi;
  assign gate[7:4] = state.summary[7:4]
                     & {4{state.mask[pia_pkg::MASK_STATUS_BIT]}};

  ////////////////////////////////////////////////////////////////////////////
  // Read side

  always_comb begin
    case (req.addr)
      pia_pkg::ADDR_SUMMARY: rd_data = state.summary;
      pia_pkg::ADDR_MASK: rd_data = state.mask;
      pia_pkg::ADDR_P4_EVT: rd_data = state.p4_evt;
      pia_pkg::ADDR_P4_EVT_RC: rd_data = state.p4_evt;
      pia_pkg::ADDR_P4_DETCLS: rd_data = port4_status.det_cls;
      pia_pkg::ADDR_P4_POWER: rd_data = port4_status.power;
      pia_pkg::ADDR_P4_CFG: rd_data = state.p4_cfg;
      pia_pkg::ADDR_P4_TLIM: rd_data = state.p4_tlim;
      pia_pkg::ADDR_P4_ICUT: rd_data = state.p4_icut;
      pia_pkg::ADDR_P4_I_LO: rd_data = port4_status.i_lo;
      pia_pkg::ADDR_P4_I_HI: rd_data = port4_status.i_hi;
      pia_pkg::ADDR_P4_V_LO: rd_data = port4_status.v_lo;
      pia_pkg::ADDR_P4_V_HI: rd_data = port4_status.v_hi;
      pia_pkg::ADDR_P4_DETRES: rd_data = port4_status.detres;
      // Write-only, reserved and other ports read as zero
      default: rd_data = pia_pkg::ZERO_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic clr_all;
  logic release_cmd;
  logic rd_clear;
  logic new_masked;

  always_comb begin
    next_state = state;
    rise = src & ~state.src_q;
    clr_all = req.wr & (req.addr == pia_pkg::ADDR_GLOBAL_CMD)
              & req.wdata[pia_pkg::CMD_CLR_SUMMARY_BIT];
    release_cmd = req.wr & (req.addr == pia_pkg::ADDR_GLOBAL_CMD)
                  & req.wdata[pia_pkg::CMD_RELEASE_PIN_BIT];
    rd_clear = req.rd & (req.addr == pia_pkg::ADDR_P4_EVT_RC);
    next_state.src_q = src;

    // Summary updates ignore the mask; an event in the clear cycle survives
    if (clr_all) begin
      next_state.summary = rise;
    end else begin
      next_state.summary = (state.summary & src) | rise;
    end

    // Port four flags: new set wins over clear-on-read
    if (rd_clear) begin
      next_state.p4_evt = port4_event_set;
    end else begin
      next_state.p4_evt = state.p4_evt | port4_event_set;
    end

    // Writes to reserved addresses fall through harmlessly
    next_state.p4_strobe = pia_pkg::ZERO_BYTE;
    if (req.wr) begin
      case (req.addr)
        pia_pkg::ADDR_MASK: next_state.mask = req.wdata;
        pia_pkg::ADDR_P4_CFG: next_state.p4_cfg = req.wdata;
        pia_pkg::ADDR_P4_TLIM: next_state.p4_tlim = req.wdata;
        pia_pkg::ADDR_P4_ICUT: next_state.p4_icut = req.wdata;
        pia_pkg::ADDR_P4_STROBE: next_state.p4_strobe = req.wdata;
        default: next_state.p4_strobe = pia_pkg::ZERO_BYTE;
      endcase
    end

    // Release holds until a fresh port event, or a global event with the status mask bit set, re-arms the pin
    new_masked = |(rise & {{4{state.mask[pia_pkg::MASK_STATUS_BIT]}}, 4'hf});
    if (new_masked) begin
      next_state.released = 1'b0;
    end else if (release_cmd) begin
      next_state.released = 1'b1;
    end
    next_state.int_n = ~(|gate & ~next_state.released);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= '{summary: pia_pkg::SUMMARY_RST, src_q: 8'h00, mask: pia_pkg::MASK_RST,
                 p4_evt: pia_pkg::P4_EVT_RST, p4_cfg: pia_pkg::P4_CFG_RST,
                 p4_tlim: pia_pkg::P4_TLIM_RST, p4_icut: pia_pkg::P4_ICUT_RST,
                 p4_strobe: pia_pkg::ZERO_BYTE, released: 1'b0, int_n: 1'b1};
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops
  assign port4_configuration = state.p4_cfg;
  assign port4_limit_timing = state.p4_tlim;
  assign port4_overcurrent_threshold = state.p4_icut;
  assign port4_command_strobes = state.p4_strobe;
  assign int_n = state.int_n;

endmodule : pia_irq_core
`default_nettype wire

// ==== pia_pkg.sv ====
// Package with register map, field positions, reset values and shared types
package pia_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] ADDR_SUMMARY = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h01;
  localparam logic [7:0] ADDR_GLOBAL_CMD = 8'h0b;
  localparam logic [7:0] ADDR_P4_EVT = 8'h40;
  localparam logic [7:0] ADDR_P4_EVT_RC = 8'h41;
  localparam logic [7:0] ADDR_P4_DETCLS = 8'h42;
  localparam logic [7:0] ADDR_P4_POWER = 8'h43;
  localparam logic [7:0] ADDR_P4_CFG = 8'h44;
  localparam logic [7:0] ADDR_P4_TLIM = 8'h45;
  localparam logic [7:0] ADDR_P4_ICUT = 8'h46;
  localparam logic [7:0] ADDR_P4_STROBE = 8'h47;
  localparam logic [7:0] ADDR_P4_I_LO = 8'h49;
  localparam logic [7:0] ADDR_P4_I_HI = 8'h4a;
  localparam logic [7:0] ADDR_P4_V_LO = 8'h4b;
  localparam logic [7:0] ADDR_P4_V_HI = 8'h4c;
  localparam logic [7:0] ADDR_P4_DETRES = 8'h4d;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] SUMMARY_RST = 8'h20;
  localparam logic [7:0] MASK_RST = 8'h80;
  localparam logic [7:0] P4_EVT_RST = 8'h00;
  localparam logic [7:0] P4_CFG_RST = 8'h00;
  localparam logic [7:0] P4_TLIM_RST = 8'h00;
  localparam logic [7:0] P4_ICUT_RST = 8'h54;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CMD_CLR_SUMMARY_BIT = 7;
  localparam int CMD_RELEASE_PIN_BIT = 6;
  localparam int MASK_STATUS_BIT = 7;
  localparam int MASK_IFAULT_BIT = 6;
  localparam int SUM_GLOBAL_LSB = 4;
  localparam int NUM_PORTS = 4;
  localparam int OTHER_PORTS = 3;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Serial slave types
  typedef enum logic [3:0] {
    SER_IDLE = 4'h0,
    SER_ADDR = 4'h1,
    SER_ADDR_ACK = 4'h2,
    SER_REG = 4'h3,
    SER_WACK = 4'h4,
    SER_WDATA = 4'h5,
    SER_RDATA = 4'h6,
    SER_RACK = 4'h7,
    SER_RLOAD = 4'h8
  } pia_ser_st_t;

  typedef struct packed {
    pia_ser_st_t st;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic [7:0] ptr;
    logic rw;
    logic sda_oe;
    logic scl_q;
    logic sda_q;
  } pia_ser_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pia_reg_req_t;

  ////////////////////////////////////////////////////////////////////////////
  // Port four measurement and status inputs
  typedef struct packed {
    logic [7:0] det_cls;
    logic [7:0] power;
    logic [7:0] i_lo;
    logic [7:0] i_hi;
    logic [7:0] v_lo;
    logic [7:0] v_hi;
    logic [7:0] detres;
  } pia_p4_status_t;

  ////////////////////////////////////////////////////////////////////////////
  // Core state
  typedef struct packed {
    logic [7:0] summary;
    logic [7:0] src_q;
    logic [7:0] mask;
    logic [7:0] p4_evt;
    logic [7:0] p4_cfg;
    logic [7:0] p4_tlim;
    logic [7:0] p4_icut;
    logic [7:0] p4_strobe;
    logic released;
    logic int_n;
  } pia_core_state_t;

endpackage : pia_pkg

// ==== pia_sync.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pia_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Asynchronous inputs and filtered result
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // Stages 0..2 then accepted value; idle-high lines reset high
  logic [3:0][W-1:0] state;
  logic [3:0][W-1:0] next_state;

  always_comb begin
    next_state[0] = async_in;
    next_state[1] = state[0];
    next_state[2] = state[1];
    // First stage feeds only the second; accept once stages two and three agree
    next_state[3] = (state[1] == state[2]) ? state[2] : state[3];
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= '1;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state[3];

endmodule : pia_sync
`default_nettype wire

// ==== pia_serial.sv ====
// Serial register link slave: address, register pointer, data bytes
`timescale 1ns/1ps
`default_nettype none
module pia_serial #(
  parameter logic [6:0] DEV_ADDR = 7'h20
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Synchronised link lines
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe,
  // Register access
  output var pia_pkg::pia_reg_req_t req,
  input wire logic [7:0] rd_data
);

  pia_pkg::pia_ser_state_t state;
  pia_pkg::pia_ser_state_t next_state;
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;

  always_comb begin
    next_state = state;
    next_state.scl_q = scl;
    next_state.sda_q = sda;
    rise = scl & ~state.scl_q;
    fall = ~scl & state.scl_q;
    start_c = scl & state.scl_q & state.sda_q & ~sda;
    stop_c = scl & state.scl_q & ~state.sda_q & sda;
    req.addr = state.ptr;
    req.wdata = state.sh;
    req.wr = fall & (state.st == pia_pkg::SER_WDATA) & (state.cnt == pia_pkg::BYTE_BITS);
    req.rd = fall & (((state.st == pia_pkg::SER_ADDR_ACK) & state.rw)
             | (state.st == pia_pkg::SER_RLOAD));
    if (start_c) begin
      next_state.st = pia_pkg::SER_ADDR;
      next_state.cnt = 4'h0;
      next_state.sda_oe = 1'b0;
    end else if (stop_c) begin
      next_state.st = pia_pkg::SER_IDLE;
      next_state.sda_oe = 1'b0;
    end else if (rise) begin
      case (state.st)
        pia_pkg::SER_ADDR, pia_pkg::SER_REG, pia_pkg::SER_WDATA: begin
          next_state.sh = {state.sh[6:0], sda};
          next_state.cnt = state.cnt + 4'h1;
        end
        pia_pkg::SER_RDATA: begin
          next_state.cnt = state.cnt + 4'h1;
        end
        pia_pkg::SER_RACK: begin
          // Not-acknowledge ends the read burst
          next_state.st = sda ? pia_pkg::SER_IDLE : pia_pkg::SER_RLOAD;
        end
        default: begin
          next_state.st = state.st;
        end
      endcase
    end else if (fall) begin
      case (state.st)
        pia_pkg::SER_ADDR: begin
          if (state.cnt == pia_pkg::BYTE_BITS) begin
            if (state.sh[7:1] == DEV_ADDR) begin
              next_state.rw = state.sh[0];
              next_state.sda_oe = 1'b1;
              next_state.st = pia_pkg::SER_ADDR_ACK;
            end else begin
              next_state.st = pia_pkg::SER_IDLE;
            end
          end
        end
        pia_pkg::SER_ADDR_ACK: begin
          next_state.cnt = 4'h0;
          if (state.rw) begin
            next_state.sh = rd_data;
            next_state.sda_oe = ~rd_data[7];
            next_state.st = pia_pkg::SER_RDATA;
          end else begin
            next_state.sda_oe = 1'b0;
            next_state.st = pia_pkg::SER_REG;
          end
        end
        pia_pkg::SER_REG: begin
          if (state.cnt == pia_pkg::BYTE_BITS) begin
            next_state.ptr = state.sh;
            next_state.sda_oe = 1'b1;
            next_state.st = pia_pkg::SER_WACK;
          end
        end
        pia_pkg::SER_WACK: begin
          next_state.sda_oe = 1'b0;
          next_state.cnt = 4'h0;
          next_state.st = pia_pkg::SER_WDATA;
        end
        pia_pkg::SER_WDATA: begin
          if (state.cnt == pia_pkg::BYTE_BITS) begin
            // Pointer steps so bursts walk the map
            next_state.ptr = state.ptr + 8'h01;
            next_state.sda_oe = 1'b1;
            next_state.st = pia_pkg::SER_WACK;
          end
        end
        pia_pkg::SER_RDATA: begin
          if (state.cnt == pia_pkg::BYTE_BITS) begin
            next_state.sda_oe = 1'b0;
            next_state.ptr = state.ptr + 8'h01;
            next_state.st = pia_pkg::SER_RACK;
          end else begin
            next_state.sh = {state.sh[6:0], 1'b0};
            next_state.sda_oe = ~state.sh[6];
          end
        end
        pia_pkg::SER_RLOAD: begin
          next_state.cnt = 4'h0;
          next_state.sh = rd_data;
          next_state.sda_oe = ~rd_data[7];
          next_state.st = pia_pkg::SER_RDATA;
        end
        default: begin
          next_state.st = state.st;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= '{st: pia_pkg::SER_IDLE, sh: 8'h00, cnt: 4'h0, ptr: 8'h00, rw: 1'b0,
                 sda_oe: 1'b0, scl_q: 1'b1, sda_q: 1'b1};
    end else begin
      state <= next_state;
    end
  end

  assign sda_oe = state.sda_oe;

endmodule : pia_serial
`default_nettype wire

// ==== pia_irq_chk.sv ====
// Port-level assertions for the interrupt summary core
`timescale 1ns/1ps
`default_nettype none
module pia_irq_chk (
  // Clock, reset and link
  input wire logic clock,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Sources and outputs
  input wire logic [3:0] global_event_hi,
  input wire logic [2:0][7:0] other_port_events,
  input wire logic [7:0] port4_event_set,
  input wire pia_pkg::pia_p4_status_t port4_status,
  input wire logic [7:0] port4_configuration,
  input wire logic [7:0] port4_limit_timing,
  input wire logic [7:0] port4_overcurrent_threshold,
  input wire logic [7:0] port4_command_strobes,
  input wire logic int_n
);
  logic [3:0] geh_q;
  logic [2:0][7:0] ope_q;
  logic [2:0] act_q;
  // Recent source activity; port four flags lag their pulse by one cycle
  always_ff @(posedge clock) begin
    geh_q <= global_event_hi;
    ope_q <= other_port_events;
    act_q <= {act_q[1:0], srst || port4_event_set != 8'h00 || global_event_hi != geh_q ||
              other_port_events != ope_q};
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  AST_RESET_PIN: assert property ($fell(srst) |-> int_n && !sda_oe)
    else $error("pin or data line active after reset");
  AST_RESET_REGS: assert property ($fell(srst) |-> port4_configuration == 8'h00 &&
      port4_limit_timing == 8'h00 && port4_overcurrent_threshold == 8'h54)
    else $error("port four registers not at reset values");
  AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
    else $error("data output not held low");
  AST_STROBE_PULSE: assert property (port4_command_strobes != 8'h00 |=>
      (port4_command_strobes == 8'h00) [*8])
    else $error("command strobe longer than one cycle");
  AST_WRITE_ON_LOW: assert property (($changed(port4_configuration) ||
      $changed(port4_limit_timing) || $changed(port4_overcurrent_threshold) ||
      port4_command_strobes != 8'h00) |-> !scl_in)
    else $error("register write outside serial clock low");
  AST_PIN_FALL_CAUSE: assert property ($fell(int_n) |-> act_q != 3'b000 || !scl_in)
    else $error("pin asserted without a new source or mask write");
  AST_PIN_RISE_CAUSE: assert property ($rose(int_n) |-> act_q != 3'b000 || !scl_in)
    else $error("pin released without source drop or command");
  AST_ACK_ON_LOW: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed while serial clock high");
endmodule : pia_irq_chk

bind pia_irq_core pia_irq_chk pia_irq_chk_i (.clock(clock), .srst(srst), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .global_event_hi(global_event_hi),
  .other_port_events(other_port_events), .port4_event_set(port4_event_set),
  .port4_status(port4_status), .port4_configuration(port4_configuration),
  .port4_limit_timing(port4_limit_timing),
  .port4_overcurrent_threshold(port4_overcurrent_threshold),
  .port4_command_strobes(port4_command_strobes), .int_n(int_n));
`default_nettype wire

// ==== pia_host.sv ====
// Host model: serial master doing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module pia_host #(
  parameter logic [6:0] DEV_ADDR = 7'h20
) (
  // Clock and line
  input wire logic clock,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_drv
);
  int nacks = 0;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wt
  task automatic start_c;
    wt(3);
    sda_drv = 1'b1;
    wt(10);
    scl = 1'b1;
    wt(10);
    sda_drv = 1'b0;
    wt(10);
    scl = 1'b0;
  endtask : start_c
  // Nine clocks, MSB first, ninth bit is acknowledge; clock held low for 13 clocks, high for 10
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      wt(3);
      sda_drv = (i == 0) ? ack_in : tx[i-1];
      wt(10);
      scl = 1'b1;
      wt(10);
      r[i] = sda_wire;
      scl = 1'b0;
    end
  endtask : xfer
  task automatic send(input logic [7:0] b);
    logic [8:0] r;
    xfer(b, 1'b1, r);
    if (r[0]) nacks++;
  endtask : send
  task automatic stop_c;
    wt(3);
    sda_drv = 1'b0;
    wt(10);
    scl = 1'b1;
    wt(10);
    sda_drv = 1'b1;
    wt(10);
  endtask : stop_c
  // Write callers pass mapped addresses only; reads also probe unmapped 02 and 48
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    start_c();
    send({DEV_ADDR, 1'b0});
    send(a);
    send(d);
    stop_c();
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic [8:0] r;
    start_c();
    send({DEV_ADDR, 1'b0});
    send(a);
    start_c();
    send({DEV_ADDR, 1'b1});
    xfer(8'hff, 1'b1, r);
    d = r[8:1];
    stop_c();
  endtask : read_reg
endmodule : pia_host
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the interrupt summary core
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock, srst, scl, sda_drv, sda_wire, sda_out, sda_oe, int_n;
  logic [3:0] geh;
  logic [2:0][7:0] ope;
  logic [7:0] p4_set, cfg, tlim, icut, strb;
  logic [7:0] strb_seen = 8'h00;
  logic [7:0] m_sum, m_old, m_mask, m_p4;
  logic m_rel;
  pia_pkg::pia_p4_status_t p4_st;
  int n_errors = 0;
  int tests_run = 0;
  int seed;
  // Pull-up: line low only when someone drives it
  assign sda_wire = sda_drv & (sda_oe ? sda_out : 1'b1);
  pia_irq_core pia_irq_core_i (.clock(clock), .srst(srst), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .global_event_hi(geh), .other_port_events(ope),
    .port4_event_set(p4_set), .port4_status(p4_st), .port4_configuration(cfg),
    .port4_limit_timing(tlim), .port4_overcurrent_threshold(icut),
    .port4_command_strobes(strb), .int_n(int_n));
  pia_host pia_host_i (.clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) if (strb !== 8'h00) strb_seen <= strb;
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  // Model: bits set on a rising source, kept while it stays, dropped with it
  task automatic upd;
    logic [7:0] s;
    logic [7:0] r;
    s = {geh, |m_p4, |ope[2], |ope[1], |ope[0]};
    r = s & ~m_old;
    m_sum = (m_sum & s) | r;
    if (r[3:0] != 4'h0 || (r[7:4] != 4'h0 && m_mask[7])) m_rel = 1'b0;
    m_old = s;
  endtask : upd
  function automatic logic exp_pin();
    logic [7:0] em;
    logic p;
    em = {m_mask[6], m_mask[6:0]};
    p = m_mask[7] && m_sum[7:4] != 4'h0;
    for (int k = 0; k < 4; k++) begin
      if (m_sum[k] && ((k == 3 ? m_p4 : ope[k % 3]) & em) != 8'h00) p = 1'b1;
    end
    return !(p && !m_rel);
  endfunction : exp_pin
  task automatic settle;
    logic [7:0] d;
    cyc(4);
    check({7'h00, int_n}, {7'h00, exp_pin()});
    pia_host_i.read_reg(pia_pkg::ADDR_SUMMARY, d);
    check(d, m_sum);
    check({7'h00, int_n}, {7'h00, exp_pin()});
  endtask : settle
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [63:0] r;
    logic [7:0] d;
    logic [7:0] ra [15];
    logic [119:0] ev;
    seed = 32'h28b4;
    srst = 1'b1;
    geh = 4'h2;
    ope = '0;
    p4_set = 8'h00;
    r = {$random(seed), $random(seed)};
    p4_st = r[55:0];
    {m_sum, m_old, m_mask, m_p4, m_rel} = {8'h20, 8'h20, 8'h80, 8'h00, 1'b0};
    cyc(10);
    srst = 1'b0;
    cyc(6);
    settle();
    ra = '{8'h01, 8'h44, 8'h45, 8'h46, 8'h47, 8'h40, 8'h02, 8'h48, 8'h42, 8'h43, 8'h49,
           8'h4a, 8'h4b, 8'h4c, 8'h4d};
    ev = {8'h80, 8'h00, 8'h00, 8'h54, 32'h0, p4_st};
    for (int i = 0; i < 15; i++) begin
      pia_host_i.read_reg(ra[i], d);
      check(d, ev[119 - 8 * i -: 8]);
    end
    $display("test reset_map done");
    for (int i = 0; i < 8; i++) begin
      r = {$random(seed), $random(seed)};
      pia_host_i.write_reg(pia_pkg::ADDR_MASK, r[47:40]);
      m_mask = r[47:40];
      geh = r[35:32];
      ope = (i % 3 == 0) ? 24'h000000 : r[23:0];
      upd();
      settle();
    end
    $display("test random_sources done");
    {geh, ope} = '0;
    pia_host_i.write_reg(pia_pkg::ADDR_MASK, 8'hff);
    m_mask = 8'hff;
    upd();
    for (int i = 0; i < 8; i++) begin
      p4_set = 8'h01 << i;
      cyc(1);
      p4_set = 8'h00;
      m_p4 = m_p4 | (8'h01 << i);
      upd();
      settle();
    end
    pia_host_i.read_reg(pia_pkg::ADDR_P4_EVT, d);
    check(d, 8'hff);
    pia_host_i.read_reg(pia_pkg::ADDR_P4_EVT_RC, d);
    check(d, 8'hff);
    m_p4 = 8'h00;
    upd();
    settle();
    $display("test port_four done");
    geh = 4'hc;
    ope[1] = 8'h10;
    upd();
    settle();
    pia_host_i.write_reg(pia_pkg::ADDR_GLOBAL_CMD, 8'h40);
    m_rel = 1'b1;
    settle();
    pia_host_i.write_reg(pia_pkg::ADDR_GLOBAL_CMD, 8'h80);
    m_sum = 8'h00;
    settle();
    ope[2] = 8'h02;
    upd();
    settle();
    pia_host_i.write_reg(pia_pkg::ADDR_MASK, 8'h00);
    m_mask = 8'h00;
    geh = 4'hf;
    upd();
    settle();
    $display("test commands_mask done");
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      pia_host_i.write_reg(8'h44 + 8'(i), d);
      cyc(2);
      ev[31:0] = {cfg, tlim, icut, strb_seen};
      check(ev[31 - 8 * i -: 8], d);
      pia_host_i.read_reg(8'h44 + 8'(i), r[7:0]);
      check(r[7:0], (i == 3) ? 8'h00 : d);
    end
    check(8'(pia_host_i.nacks), 8'h00);
    $display("test port_regs done");
    test_done();
  end
  initial begin
    cyc(95000);
    n_errors++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
